// *** tcg_cfg.svh ***
// register offsets, field positions, and reset and restart values of the capture/gated timer
`ifndef TCG_CFG_SVH
`define TCG_CFG_SVH

// ==========================================
// register offsets (word index on the register port)
`define TCG_ADDR_CTRL 4'h0
`define TCG_ADDR_COUNT 4'h1
`define TCG_ADDR_RELOAD 4'h2
`define TCG_ADDR_CAPTURE 4'h3
`define TCG_ADDR_STATUS 4'h4
`define TCG_ADDR_MASK 4'h5

// ==========================================
// control register fields
`define TCG_CTRL_EN_BIT 0
`define TCG_CTRL_MODE_LSB 1
`define TCG_CTRL_POL_BIT 3
`define TCG_CTRL_PRE_LSB 4
`define TCG_CTRL_SRC_LSB 7
`define TCG_CTRL_CAUSE_BIT 9

// ==========================================
// status register fields
`define TCG_ST_CAPTURE_BIT 0
`define TCG_ST_RELOAD_BIT 1
`define TCG_ST_GATE_BIT 2

// ==========================================
// reset and restart values
`define TCG_COUNT_RESTART 16'h0001
`define TCG_COUNT_RESET 16'h0000
`define TCG_RELOAD_RESET 16'hFFFF
`define TCG_CAPTURE_RESET 16'h0000

`endif

// *** tcg_pkg.sv ***
// types of the capture/gated timer
package tcg_pkg;

  // ==========================================
  // operating modes
  typedef enum logic [1:0]
  {
    TCG_MODE_CAPTURE = 2'b00,
    TCG_MODE_GATED = 2'b01,
    TCG_MODE_CAPCMP = 2'b10,
    TCG_MODE_SPARE = 2'b11
  } tcg_mode_t;

  // ==========================================
  // gated-mode interrupt source select
  typedef enum logic [1:0]
  {
    TCG_SRC_BOTH = 2'b00,
    TCG_SRC_BOTH_ALT = 2'b01,
    TCG_SRC_GATE = 2'b10,
    TCG_SRC_RELOAD = 2'b11
  } tcg_src_t;

  // ==========================================
  // capture/compare run state
  typedef enum logic [0:0]
  {
    TCG_CC_ARMED = 1'b0,
    TCG_CC_RUN = 1'b1
  } tcg_cc_state_t;

endpackage : tcg_pkg

// *** tcg_prescaler.sv ***
// prescaler: one count-enable pulse per 2**ratio system clocks
`timescale 1ns/1ps

module tcg_prescaler #(
  parameter int PRE_W = 3
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic [PRE_W-1:0] ratio_i,
  output logic tick_o
);

  localparam int DIV_W = (1 << PRE_W) - 1;

  initial
  begin
    if (PRE_W < 1 || PRE_W > 4)
    begin
      $error("tcg_prescaler: PRE_W out of range");
    end
  end

  logic [DIV_W-1:0] div_ff;
  logic [DIV_W-1:0] mask;
  logic tick_ff;

  assign mask = DIV_W'((1 << ratio_i) - 1);

  // ==========================================
  // divider
  // R18 - prescale divide
  always_ff @(posedge clock_i)
  begin
    if (rst_i || !run_i)
    begin
      div_ff <= '0;
      tick_ff <= 1'b0;
    end
    else
    begin
      tick_ff <= ((div_ff & mask) == mask);
      div_ff <= ((div_ff & mask) == mask) ? '0 : div_ff + 1'b1;
    end
  end

  assign tick_o = tick_ff;

  // R18 - single pulse spacing
  chk_tick_single: assert property (@(posedge clock_i) disable iff (rst_i) // R18
    (tick_ff && ratio_i != '0 && $stable(ratio_i) && run_i) |=> !tick_ff)
    else $error("prescaler tick repeated");

endmodule : tcg_prescaler

// *** tcg_timer.sv ***
// 16-bit timer with capture, gated and capture/compare modes
//
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`include "tcg_cfg.svh"

// Summary of operation
// R1 - capture mode copies count on edge
// R2 - counter advances on prescaled system clock
// R3 - polarity bit picks rising or falling
// R4 - capture sets interrupt and cause, keeps counting
// R5 - reload match interrupts, clears cause, continues
// R6 - software disables, then sets mode, prescale
// R7 - software preloads count and reload first
// R8 - software clears capture value before start
// R9 - zero capture after interrupt means reload
// R10 - gated restarts from 0001H after reload match
// R11 - gated interrupts on deassert and reload
// R12 - external party asserts input to count
// R13 - capcompare idles until first qualifying edge
// R14 - later edges capture the count
// R15 - capcompare capture interrupts, restarts at 0001H
// R16 - compare match interrupts, clears cause, restarts
// R17 - software disables before capcompare setup
// R18 - prescaler gives one enable per period
// R19 - input synchronised, capture after edge detect
module tcg_timer #(
  parameter int PRE_W = 3
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic timer_in_i,
  output logic [15:0] rdata_o,
  output logic irq_o
);

  initial
  begin
    if (PRE_W != 3)
    begin
      $error("tcg_timer: control layout needs PRE_W of 3");
    end
  end

  // ==========================================
  // register state
  logic enable_ff;
  tcg_pkg::tcg_mode_t mode_ff;
  logic input_edge_polarity_ff;
  logic [PRE_W-1:0] prescale_ff;
  tcg_pkg::tcg_src_t interrupt_source_select_ff;
  logic capture_cause_flag_ff;
  logic [15:0] count_ff;
  logic [15:0] reload_ff;
  logic [15:0] capture_ff;
  logic [2:0] status_ff;
  logic [2:0] mask_ff;
  logic [15:0] rdata_ff;
  logic irq_ff;
  tcg_pkg::tcg_cc_state_t cc_state_ff;

  // ==========================================
  // input synchroniser and edge detect
  logic sync1_ff;
  logic sync2_ff;
  logic prev_ff;
  logic edge_ff;
  logic fall_raw;
  logic rise_raw;

  // R19 - two-stage synchroniser
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      prev_ff <= 1'b0;
    end
    else
    begin
      sync1_ff <= timer_in_i;
      sync2_ff <= sync1_ff;
      prev_ff <= sync2_ff;
    end
  end

  assign rise_raw = sync2_ff && !prev_ff;
  assign fall_raw = !sync2_ff && prev_ff;

  // R3 - polarity selects edge
  // R19 - event one cycle after detect
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      edge_ff <= 1'b0;
    end
    else
    begin
      edge_ff <= input_edge_polarity_ff ? fall_raw : rise_raw;
    end
  end

  // gate deassertion is the opposite level change of the asserted state
  logic gate_active;
  logic gate_fall;
  assign gate_active = input_edge_polarity_ff ? !sync2_ff : sync2_ff;
  assign gate_fall = input_edge_polarity_ff ? rise_raw : fall_raw;

  // ==========================================
  // prescaler
  logic tick;
  logic pre_run;

  assign pre_run = enable_ff && !(mode_ff == tcg_pkg::TCG_MODE_CAPCMP && cc_state_ff == tcg_pkg::TCG_CC_ARMED);

  tcg_prescaler #(
    .PRE_W(PRE_W)
  ) u_tcg_prescaler (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .run_i(pre_run),
    .ratio_i(prescale_ff),
    .tick_o(tick)
  );

  // ==========================================
  // event decode
  logic in_capture;
  logic in_gated;
  logic in_capcmp;
  logic cap_event;
  logic cc_capture;
  logic reload_hit;
  logic gate_event;
  logic count_step;

  assign in_capture = enable_ff && mode_ff == tcg_pkg::TCG_MODE_CAPTURE;
  assign in_gated = enable_ff && mode_ff == tcg_pkg::TCG_MODE_GATED;
  assign in_capcmp = enable_ff && mode_ff == tcg_pkg::TCG_MODE_CAPCMP;
  assign cap_event = in_capture && edge_ff;
  assign cc_capture = in_capcmp && cc_state_ff == tcg_pkg::TCG_CC_RUN && edge_ff;
  assign gate_event = in_gated && gate_fall;
  // R2 - count from prescaled clock only
  assign count_step = tick && (!in_gated || gate_active);
  assign reload_hit = count_step && count_ff == reload_ff && enable_ff && !cc_capture;

  function automatic logic reg_hit(input logic strobe, input logic [3:0] a, input logic [3:0] want);
    reg_hit = strobe && (a == want);
  endfunction : reg_hit

  // ==========================================
  // capture/compare start
  // R13 - idle until first edge
  always_ff @(posedge clock_i)
  begin
    if (rst_i || !in_capcmp)
    begin
      cc_state_ff <= tcg_pkg::TCG_CC_ARMED;
    end
    else
    begin
      unique case (cc_state_ff)
        tcg_pkg::TCG_CC_ARMED:
        begin
          if (edge_ff)
          begin
            cc_state_ff <= tcg_pkg::TCG_CC_RUN;
          end
        end
        tcg_pkg::TCG_CC_RUN:
        begin
          cc_state_ff <= tcg_pkg::TCG_CC_RUN;
        end
      endcase
    end
  end

  // ==========================================
  // control register
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      enable_ff <= 1'b0;
      mode_ff <= tcg_pkg::TCG_MODE_CAPTURE;
      input_edge_polarity_ff <= 1'b0;
      prescale_ff <= '0;
      interrupt_source_select_ff <= tcg_pkg::TCG_SRC_BOTH;
    end
    else if (reg_hit(wr_i, addr_i, `TCG_ADDR_CTRL))
    begin
      enable_ff <= wdata_i[`TCG_CTRL_EN_BIT];
      mode_ff <= tcg_pkg::tcg_mode_t'(wdata_i[`TCG_CTRL_MODE_LSB +: 2]);
      input_edge_polarity_ff <= wdata_i[`TCG_CTRL_POL_BIT];
      prescale_ff <= wdata_i[`TCG_CTRL_PRE_LSB +: PRE_W];
      interrupt_source_select_ff <= tcg_pkg::tcg_src_t'(wdata_i[`TCG_CTRL_SRC_LSB +: 2]);
    end
  end

  // capture cause flag: hardware set/clear wins over a software write
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      capture_cause_flag_ff <= 1'b0;
    end
    // R4 - capture sets cause
    // R15 - capcompare capture sets cause
    else if (cap_event || cc_capture)
    begin
      capture_cause_flag_ff <= 1'b1;
    end
    // R5 - reload clears cause
    // R16 - compare clears cause
    else if (reload_hit)
    begin
      capture_cause_flag_ff <= 1'b0;
    end
    else if (reg_hit(wr_i, addr_i, `TCG_ADDR_CTRL))
    begin
      capture_cause_flag_ff <= wdata_i[`TCG_CTRL_CAUSE_BIT];
    end
  end

  // ==========================================
  // counter
  logic first_pass_ff;

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      count_ff <= `TCG_COUNT_RESET;
      first_pass_ff <= 1'b1;
    end
    else if (reg_hit(wr_i, addr_i, `TCG_ADDR_COUNT))
    begin
      count_ff <= wdata_i;
      first_pass_ff <= 1'b1;
    end
    // R15 - capture restarts count
    else if (cc_capture)
    begin
      count_ff <= `TCG_COUNT_RESTART;
    end
    // R10 - later passes from 0001H
    // R16 - compare restarts count
    else if (reload_hit && !in_capture)
    begin
      count_ff <= `TCG_COUNT_RESTART;
      first_pass_ff <= 1'b0;
    end
    // R4 - capture mode keeps counting
    // R5 - reload in capture mode continues
    else if (count_step && enable_ff)
    begin
      count_ff <= count_ff + 16'h0001;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      reload_ff <= `TCG_RELOAD_RESET;
    end
    else if (reg_hit(wr_i, addr_i, `TCG_ADDR_RELOAD))
    begin
      reload_ff <= wdata_i;
    end
  end

  // ==========================================
  // capture value
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      capture_ff <= `TCG_CAPTURE_RESET;
    end
    // R1 - latch count on edge
    // R14 - later edges capture
    else if (cap_event || cc_capture)
    begin
      capture_ff <= count_ff;
    end
    else if (reg_hit(wr_i, addr_i, `TCG_ADDR_CAPTURE))
    begin
      capture_ff <= wdata_i;
    end
  end

  // ==========================================
  // interrupt status, mask and output
  logic [2:0] ev;
  logic gate_src_ok;
  logic reload_src_ok;

  // R11 - source select filter
  assign gate_src_ok = interrupt_source_select_ff != tcg_pkg::TCG_SRC_RELOAD;
  assign reload_src_ok = !in_gated || interrupt_source_select_ff != tcg_pkg::TCG_SRC_GATE;
  assign ev[`TCG_ST_CAPTURE_BIT] = cap_event || cc_capture;
  assign ev[`TCG_ST_RELOAD_BIT] = reload_hit && reload_src_ok;
  assign ev[`TCG_ST_GATE_BIT] = gate_event && gate_src_ok;

  // read clears; a new event in the same cycle survives
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      status_ff <= '0;
    end
    else if (reg_hit(rd_i, addr_i, `TCG_ADDR_STATUS))
    begin
      status_ff <= ev;
    end
    else
    begin
      status_ff <= status_ff | ev;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      mask_ff <= '0;
    end
    else if (reg_hit(wr_i, addr_i, `TCG_ADDR_MASK))
    begin
      mask_ff <= wdata_i[2:0];
    end
  end

  // registered one cycle behind status to keep the output a flip-flop
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      irq_ff <= 1'b0;
    end
    else
    begin
      irq_ff <= |(status_ff & mask_ff);
    end
  end

  // ==========================================
  // read port
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      rdata_ff <= '0;
    end
    else if (rd_i)
    begin
      unique case (addr_i)
        `TCG_ADDR_CTRL: rdata_ff <= {6'h00, capture_cause_flag_ff, interrupt_source_select_ff, prescale_ff,
          input_edge_polarity_ff, mode_ff, enable_ff};
        `TCG_ADDR_COUNT: rdata_ff <= count_ff;
        `TCG_ADDR_RELOAD: rdata_ff <= reload_ff;
        `TCG_ADDR_CAPTURE: rdata_ff <= capture_ff;
        `TCG_ADDR_STATUS: rdata_ff <= {13'h0000, status_ff};
        `TCG_ADDR_MASK: rdata_ff <= {13'h0000, mask_ff};
        default: rdata_ff <= 16'h0000;
      endcase
    end
    else
    begin
      rdata_ff <= 16'h0000;
    end
  end

  assign rdata_o = rdata_ff;
  assign irq_o = irq_ff;

  // ==========================================
  // checks
  chk_capture_latches: assert property (@(posedge clock_i) disable iff (rst_i) // R1
    cap_event |=> capture_ff == $past(count_ff))
    else $error("capture did not latch count");

  chk_capture_keeps_count: assert property (@(posedge clock_i) disable iff (rst_i) // R4
    (cap_event && !wr_i) |=> capture_cause_flag_ff && (count_ff - $past(count_ff)) <= 16'h0001)
    else $error("capture mode cause flag or count wrong");

  chk_reload_clears_cause: assert property (@(posedge clock_i) disable iff (rst_i) // R5
    (reload_hit && !cap_event && !cc_capture) |=> !capture_cause_flag_ff)
    else $error("reload did not clear cause");

  chk_cc_idle: assert property (@(posedge clock_i) disable iff (rst_i) // R13
    (in_capcmp && cc_state_ff == tcg_pkg::TCG_CC_ARMED && !wr_i) |=> $stable(count_ff))
    else $error("capcompare counted before first edge");

  chk_cc_restart: assert property (@(posedge clock_i) disable iff (rst_i) // R15
    (cc_capture && !wr_i) |=> count_ff == `TCG_COUNT_RESTART && capture_cause_flag_ff)
    else $error("capcompare capture did not restart");

  chk_compare_restart: assert property (@(posedge clock_i) disable iff (rst_i) // R16
    (reload_hit && in_capcmp && !wr_i) |=> count_ff == `TCG_COUNT_RESTART)
    else $error("compare did not restart");

  chk_gated_restart: assert property (@(posedge clock_i) disable iff (rst_i) // R10
    (reload_hit && in_gated && !wr_i) |=> count_ff == `TCG_COUNT_RESTART && !first_pass_ff)
    else $error("gated did not restart at one");

  chk_gate_source: assert property (@(posedge clock_i) disable iff (rst_i) // R11
    (gate_event && interrupt_source_select_ff != tcg_pkg::TCG_SRC_RELOAD) |=> status_ff[`TCG_ST_GATE_BIT])
    else $error("gate deassert not flagged");

  chk_sync_delay: assert property (@(posedge clock_i) disable iff (rst_i) // R19
    (rise_raw && !input_edge_polarity_ff) |=> edge_ff)
    else $error("edge not taken next cycle");

  chk_gated_hold: assert property (@(posedge clock_i) disable iff (rst_i) // R2
    (in_gated && !gate_active && !wr_i) |=> $stable(count_ff))
    else $error("gated counted while input idle");

  cov_capture: cover property (@(posedge clock_i) disable iff (rst_i) cap_event);
  cov_cc_capture: cover property (@(posedge clock_i) disable iff (rst_i) cc_capture);
  cov_gate: cover property (@(posedge clock_i) disable iff (rst_i) gate_event);
  cov_irq: cover property (@(posedge clock_i) disable iff (rst_i) $rose(irq_ff));

endmodule : tcg_timer

// *** tcg_pin_model.sv ***
// partner model: external source that drives the timer input pin
`timescale 1ns/1ps

module tcg_pin_model #(
  parameter int PERIOD_NS = 10
) (
  input wire logic clock_i,
  output logic pin_o
);
  time t_chg = 0;

  initial
  begin
    pin_o = 1'b0;
  end

  // ==========================================
  // pin driving
  // a level stays at least two clocks: shorter pulses may slip past the synchroniser
  // align_t and mod let the caller place a change a whole number of prescaler periods after another
  task automatic drive(input logic lvl, input int gap, input time align_t, input int mod);
    @(posedge clock_i);
    while ((($time - align_t) / PERIOD_NS) % mod != 0)
      @(posedge clock_i);
    pin_o <= lvl;
    t_chg = $time;
    repeat (((gap < 2) ? 2 : gap) - 1) @(posedge clock_i);
  endtask : drive
endmodule : tcg_pin_model

// *** tcg_timer_test.sv ***
// self-checking bench of the capture/gated timer
`timescale 1ns/1ps
`include "tcg_cfg.svh"

module tcg_timer_test;
  localparam int CYC_MAX = 20000;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic timer_in;
  logic [15:0] rdata_o;
  logic irq_o;
  logic rd_seen = 1'b0;
  logic [15:0] rv = 16'h0000;
  logic [15:0] exp_q [$];
  bit chk_q [$];
  int num_errors = 0;
  int compares = 0;
  int cyc = 0;

  initial
  begin
    forever #5 clock_i = ~clock_i;
  end

  tcg_timer #(.PRE_W(3)) u_tcg_timer (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .timer_in_i(timer_in), .rdata_o(rdata_o), .irq_o(irq_o));

  tcg_pin_model u_tcg_pin_model (.clock_i(clock_i), .pin_o(timer_in));

  // ==========================================
  // checking and closing
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop;
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  // read data stands only in the cycle after the strobe
  always @(posedge clock_i)
  begin
    if (rd_seen)
    begin
      rv = rdata_o;
      if (chk_q.pop_front())
        check(rdata_o, exp_q.pop_front());
      else
        void'(exp_q.pop_front());
    end
    rd_seen <= rd_i;
  end

  always @(posedge clock_i)
  begin
    cyc <= cyc + 1;
    if (cyc == CYC_MAX)
    begin
      num_errors++;
      report_and_stop();
    end
  end

  // ==========================================
  // register port
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [15:0] e, input bit c = 1'b1);
    exp_q.push_back(e);
    chk_q.push_back(c);
    @(posedge clock_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    rd_i <= 1'b0;
    @(posedge clock_i);
    @(negedge clock_i);
  endtask : rd

  task automatic irq_is(input logic e);
    // irq_o trails status and mask by one clock
    @(posedge clock_i);
    @(negedge clock_i);
    check({15'h0000, irq_o}, {15'h0000, e});
  endtask : irq_is

  task automatic cause_is(input logic e);
    rd(`TCG_ADDR_CTRL, 16'h0000, 1'b0);
    check({15'h0000, rv[`TCG_CTRL_CAUSE_BIT]}, {15'h0000, e});
  endtask : cause_is

  function automatic logic [15:0] ctl(input logic [1:0] md, input logic pol, input logic [2:0] pre,
    input logic [1:0] src);
    ctl = 16'h0000;
    ctl[`TCG_CTRL_MODE_LSB +: 2] = md;
    ctl[`TCG_CTRL_POL_BIT] = pol;
    ctl[`TCG_CTRL_PRE_LSB +: 3] = pre;
    ctl[`TCG_CTRL_SRC_LSB +: 2] = src;
  endfunction : ctl

  task automatic setup(input logic [15:0] c, input logic [15:0] cnt, input logic [15:0] rl);
    // disabled while mode and prescale are set
    wr(`TCG_ADDR_CTRL, c);
    wr(`TCG_ADDR_COUNT, cnt);
    wr(`TCG_ADDR_RELOAD, rl);
    wr(`TCG_ADDR_CAPTURE, 16'h0000);
    rd(`TCG_ADDR_STATUS, 16'h0000, 1'b0);
    wr(`TCG_ADDR_CTRL, c | (16'h0001 << `TCG_CTRL_EN_BIT));
  endtask : setup

  // ==========================================
  // main sequence
  initial
  begin
    logic [15:0] rst_v [7];
    logic [15:0] c1;
    logic pl;
    time t1;
    time t2;
    int n;
    rst_v = '{16'h0000, `TCG_COUNT_RESET, `TCG_RELOAD_RESET, `TCG_CAPTURE_RESET, 16'h0000, 16'h0000, 16'h0000};
    void'($urandom(15172));
    repeat (12) @(posedge clock_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 7; i++)
      rd(4'(i), rst_v[i]);
    irq_is(1'b0);
    c1 = 16'($urandom);
    wr(`TCG_ADDR_RELOAD, c1);
    rd(`TCG_ADDR_RELOAD, c1);
    wr(4'hE, 16'hFFFF);
    rd(4'hE, 16'h0000);
    // capture mode, both polarities, divide by four
    for (int p = 0; p < 2; p++)
    begin
      pl = p[0];
      u_tcg_pin_model.drive(pl, 2, 0, 1);
      wr(`TCG_ADDR_MASK, 16'h0000);
      setup(ctl(tcg_pkg::TCG_MODE_CAPTURE, pl, 3'h2, tcg_pkg::TCG_SRC_BOTH), 16'h0001, 16'hFFFF);
      u_tcg_pin_model.drive(!pl, 6, 0, 1);
      t1 = u_tcg_pin_model.t_chg;
      u_tcg_pin_model.drive(pl, 6, 0, 1);
      irq_is(1'b0);
      wr(`TCG_ADDR_MASK, 16'h0007);
      irq_is(1'b1);
      rd(`TCG_ADDR_STATUS, 16'h0001);
      irq_is(1'b0);
      cause_is(1'b1);
      rd(`TCG_ADDR_CAPTURE, 16'h0000, 1'b0);
      c1 = rv;
      n = 4 * (8 + int'($urandom % 16));
      repeat (n) @(posedge clock_i);
      u_tcg_pin_model.drive(!pl, 6, t1, 4);
      t2 = u_tcg_pin_model.t_chg;
      u_tcg_pin_model.drive(pl, 6, 0, 1);
      rd(`TCG_ADDR_CAPTURE, c1 + 16'((t2 - t1) / 40));
    end
    // capture then reload in capture mode
    u_tcg_pin_model.drive(1'b0, 2, 0, 1);
    setup(ctl(tcg_pkg::TCG_MODE_CAPTURE, 1'b0, 3'h0, tcg_pkg::TCG_SRC_BOTH), 16'h0001, 16'h0100);
    u_tcg_pin_model.drive(1'b1, 6, 0, 1);
    u_tcg_pin_model.drive(1'b0, 6, 0, 1);
    rd(`TCG_ADDR_STATUS, 16'h0001);
    cause_is(1'b1);
    repeat (300) @(posedge clock_i);
    rd(`TCG_ADDR_STATUS, 16'h0002);
    cause_is(1'b0);
    rd(`TCG_ADDR_COUNT, 16'h0000, 1'b0);
    check({15'h0000, rv > 16'h0100}, 16'h0001);
    // gated mode over every interrupt source select
    for (int s = 0; s < 4; s++)
    begin
      setup(ctl(tcg_pkg::TCG_MODE_GATED, 1'b0, 3'h0, 2'(s)), 16'h0028, 16'h0030);
      u_tcg_pin_model.drive(1'b1, 30, 0, 1);
      irq_is(s != 2);
      rd(`TCG_ADDR_STATUS, 16'h0000, 1'b0);
      u_tcg_pin_model.drive(1'b0, 8, 0, 1);
      irq_is(s != 3);
      rd(`TCG_ADDR_COUNT, 16'h0000, 1'b0);
      c1 = rv;
      rd(`TCG_ADDR_COUNT, c1);
      check({15'h0000, c1 >= 16'h0008 && c1 <= 16'h0027}, 16'h0001);
      rd(`TCG_ADDR_CAPTURE, 16'h0000);
    end
    // capture/compare mode
    setup(ctl(tcg_pkg::TCG_MODE_CAPCMP, 1'b0, 3'h0, tcg_pkg::TCG_SRC_BOTH), 16'h0001, 16'h0200);
    repeat (20) @(posedge clock_i);
    rd(`TCG_ADDR_COUNT, 16'h0001);
    u_tcg_pin_model.drive(1'b1, 6, 0, 1);
    u_tcg_pin_model.drive(1'b0, 6, 0, 1);
    rd(`TCG_ADDR_STATUS, 16'h0000);
    repeat (40) @(posedge clock_i);
    u_tcg_pin_model.drive(1'b1, 6, 0, 1);
    t1 = u_tcg_pin_model.t_chg;
    u_tcg_pin_model.drive(1'b0, 6, 0, 1);
    rd(`TCG_ADDR_STATUS, 16'h0001);
    repeat (60) @(posedge clock_i);
    u_tcg_pin_model.drive(1'b1, 6, 0, 1);
    t2 = u_tcg_pin_model.t_chg;
    u_tcg_pin_model.drive(1'b0, 6, 0, 1);
    rd(`TCG_ADDR_CAPTURE, 16'((t2 - t1) / 10));
    cause_is(1'b1);
    rd(`TCG_ADDR_STATUS, 16'h0001);
    repeat (600) @(posedge clock_i);
    rd(`TCG_ADDR_STATUS, 16'h0002);
    cause_is(1'b0);
    rd(`TCG_ADDR_COUNT, 16'h0000, 1'b0);
    check({15'h0000, rv < 16'h0100}, 16'h0001);
    report_and_stop();
  end
endmodule : tcg_timer_test
